// >>> hw/tws_pkg.sv
// package: constants and types of the two-wire slave receiver
// Notes on behaviour
// - answer only when the incoming address equals the upper seven own-address bits, or is the enabled broadcast.
// - own-address bit zero enables answering the broadcast address 0x00.
// - after set-up, wait for address; direction 0 receives, 1 transmits.
// - own address with write bit sets job_done_flag and a valid status.
// - addressed after lost master arbitration reports 0x68 or 0x78.
// - ack_enable cleared mid-transfer gives a not-acknowledge after the next byte.
// - with ack_enable zero, own address is ignored; recognition resumes when set.
// - with system clock stopped, address match still runs on the bus clock.
// - match in sleep requests wake-up; SCL held low until flag cleared by one.
// - after waking from sleep the data register need not hold the bus byte.
// - status 0x60 own address acked; next byte acked per ack_enable.
// - status 0x68 lost arbitration, own address acked; next byte per ack_enable.
// - status 0x70 broadcast address acked; next byte per ack_enable.
// - status 0x78 lost arbitration, broadcast acked; next byte per ack_enable.
// - status 0x80 data byte acked; software reads byte, then clears flag.
// - status 0x88 byte not acked; device then leaves addressed mode.
// - status codes hold with prescaler bits zero or masked to zero.
package tws_pkg;

    // ======================================================
    // register map
    localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam logic [7:0] OFS_MODE = 8'h10;

    // ======================================================
    // control register bit positions
    localparam int CTL_FLAG = 7;
    localparam int CTL_ACK_EN = 6;
    localparam int CTL_BEGIN = 5;
    localparam int CTL_HALT = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_IFACE_EN = 2;
    localparam int CTL_IRQ_EN = 0;

    // ======================================================
    // status codes, prescaler bits zero
    localparam logic [7:0] ST_OWN_W = 8'h60;
    localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
    localparam logic [7:0] ST_BCAST = 8'h70;
    localparam logic [7:0] ST_ARB_BCAST = 8'h78;
    localparam logic [7:0] ST_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_BC_DATA_ACK = 8'h90;
    localparam logic [7:0] ST_BC_DATA_NACK = 8'h98;
    localparam logic [7:0] ST_STOP = 8'hA0;
    localparam logic [7:0] ST_NO_INFO = 8'hF8;

    localparam logic [6:0] BROADCAST_ADDRESS = 7'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // event kinds passed from the link side
    localparam logic [1:0] EV_ADDR = 2'h0;
    localparam logic [1:0] EV_DATA = 2'h1;
    localparam logic [1:0] EV_TX = 2'h2;

    // ======================================================
    // types
    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_ADDR = 4'h2,
        PH_DATA = 4'h4,
        PH_SKIP = 4'h8
    } tws_phase_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } tws_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tws_apb_rsp_t;

    typedef struct packed {
        logic scl_drive;
        logic scl_oe;
        logic sda_drive;
        logic sda_oe;
    } tws_pins_t;

    typedef struct packed {
        logic [1:0] kind;
        logic gc;
        logic ack;
        logic [7:0] data;
    } tws_event_t;

    typedef struct packed {
        logic [7:0] own_addr;
        logic ack_en;
        logic begin_c;
        logic halt_c;
        logic wcol;
        logic iface_en;
        logic irq_en;
        logic flag;
        logic [1:0] prescale;
        logic [7:0] status;
        logic [7:0] data;
        logic addressed;
        logic in_gc;
        logic arb_pend;
        logic tx_mode;
        logic stretch;
        logic wake;
        logic [2:0] ev_sync;
        logic [2:0] stop_sync;
        logic link_clr;
        logic pin_low;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tws_sys_t;

    typedef struct packed {
        tws_phase_t phase;
        logic [3:0] bit_cnt;
        logic [6:0] shift;
        logic start_seen;
        logic ack_due;
        logic ev_tgl;
        tws_event_t ev;
        logic [8:0] cfg_s1;
        logic [8:0] cfg_s2;
    } tws_link_t;

    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [1:0] PRESCALE_RST = 2'h0;

    localparam tws_sys_t SYS_RST = '{
        own_addr: OWN_ADDR_RST,
        prescale: PRESCALE_RST,
        status: ST_NO_INFO,
        link_clr: 1'b1,
        default: '0
    };

    localparam tws_link_t LINK_RST = '{phase: PH_IDLE, default: '0};

endpackage : tws_pkg

// >>> hw/tws_receiver.sv
// two-wire slave receiver: register slave, bus-clock link logic, crossings
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module tws_receiver (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire tws_pkg::tws_apb_req_t apb_req_in,
    output tws_pkg::tws_apb_rsp_t apb_rsp_out,
    input wire logic scl_clk_in,
    input wire logic sda_in,
    output tws_pkg::tws_pins_t pins_out,
    input wire logic sleep_in,
    input wire logic arb_lost_in,
    output logic wake_req_out
);
    import tws_pkg::*;

    tws_sys_t s;
    tws_sys_t next_s;
    tws_link_t l;
    tws_link_t next_l;
    logic sda_oe;
    logic next_sda_oe;
    logic start_tgl;
    logic stop_tgl;
    logic [7:0] byte_v;
    logic own_hit;
    logic bc_hit;
    logic access;
    logic ev_new;
    logic stop_new;
    logic ctl_wr;
    logic clear_req;

    // ======================================================
    // start and stop detection on the data line
    // only meaningful while SCL is high; toggles avoid a pulse that the
    // stopped bus clock could never see
    always_ff @(negedge sda_in or posedge s.link_clr) begin
        if (s.link_clr) begin
            start_tgl <= 1'b0;
        end else if (scl_clk_in) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge sda_in or posedge s.link_clr) begin
        if (s.link_clr) begin
            stop_tgl <= 1'b0;
        end else if (scl_clk_in) begin
            stop_tgl <= ~stop_tgl;
        end
    end

    // ======================================================
    // link side, clocked by SCL
    assign byte_v = {l.shift, sda_in};
    assign own_hit = (byte_v[7:1] == l.cfg_s2[7:1]);
    assign bc_hit = (byte_v[7:1] == BROADCAST_ADDRESS) && l.cfg_s2[0];

    always_comb begin
        next_l = l;
        // config is quasi-static; own address changes only between transfers, ack_enable also mid-transfer
        next_l.cfg_s1 = {s.ack_en, s.own_addr};
        next_l.cfg_s2 = l.cfg_s1;
        if (start_tgl != l.start_seen) begin
            next_l.start_seen = start_tgl;
            next_l.phase = PH_ADDR;
            next_l.bit_cnt = 4'h1;
            next_l.shift = {6'h00, sda_in};
            next_l.ack_due = 1'b0;
        end else if (l.phase == PH_ADDR || l.phase == PH_DATA) begin
            if (l.bit_cnt < BIT_LAST) begin
                next_l.shift = {l.shift[5:0], sda_in};
                next_l.bit_cnt = l.bit_cnt + 4'h1;
            end else if (l.bit_cnt == BIT_LAST) begin
                next_l.bit_cnt = BIT_ACK;
                next_l.ev.data = byte_v;
                if (l.phase == PH_ADDR) begin
                    // no answer while ack_enable is low, the bus is still watched
                    next_l.ack_due = l.cfg_s2[8] && (own_hit || (bc_hit && !byte_v[0]));
                    next_l.ev.gc = bc_hit && !own_hit;
                    next_l.ev.kind = byte_v[0] ? EV_TX : EV_ADDR;
                end else begin
                    next_l.ack_due = l.cfg_s2[8];
                    next_l.ev.kind = EV_DATA;
                end
            end else begin
                next_l.bit_cnt = 4'h0;
                next_l.ev.ack = l.ack_due;
                if (l.ack_due || l.phase == PH_DATA) begin
                    next_l.ev_tgl = ~l.ev_tgl;
                end
                if (l.ack_due && l.ev.kind != EV_TX) begin
                    next_l.phase = PH_DATA;
                end else begin
                    // transmit side and refused bytes are not followed further
                    next_l.phase = PH_SKIP;
                end
            end
        end
    end

    always_ff @(posedge scl_clk_in or posedge s.link_clr) begin
        if (s.link_clr) begin
            l <= LINK_RST;
        end else begin
            l <= next_l;
        end
    end

    // acknowledge driven from the falling edge so SDA never moves with SCL high
    assign next_sda_oe = (l.bit_cnt == BIT_ACK) && l.ack_due &&
        (l.phase == PH_ADDR || l.phase == PH_DATA);

    always_ff @(negedge scl_clk_in or posedge s.link_clr) begin
        if (s.link_clr) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= next_sda_oe;
        end
    end

    // ======================================================
    // system side: crossings, registers, status
    // event payload stays still for eight bus clocks after its toggle
    assign ev_new = s.ev_sync[1] ^ s.ev_sync[2];
    assign stop_new = s.stop_sync[1] ^ s.stop_sync[2];
    assign access = apb_req_in.psel && apb_req_in.penable && s.pready;
    assign ctl_wr = access && apb_req_in.pwrite && apb_req_in.paddr == OFS_CONTROL;
    assign clear_req = ctl_wr && apb_req_in.pwdata[CTL_FLAG];

    always_comb begin
        next_s = s;
        next_s.ev_sync = {s.ev_sync[1:0], l.ev_tgl};
        next_s.stop_sync = {s.stop_sync[1:0], stop_tgl};
        next_s.link_clr = !s.iface_en;
        next_s.pin_low = 1'b0;
        if (arb_lost_in) begin
            next_s.arb_pend = 1'b1;
        end

        // register bus, zero wait: ready in every access phase
        next_s.pready = apb_req_in.psel && !apb_req_in.penable;
        next_s.pslverr = 1'b0;
        next_s.prdata = 32'h0000_0000;
        if (apb_req_in.psel && !apb_req_in.penable) begin
            case (apb_req_in.paddr)
                OFS_OWN_ADDR: next_s.prdata = {24'h00_0000, s.own_addr};
                OFS_CONTROL: next_s.prdata = {24'h00_0000, s.flag, s.ack_en, s.begin_c,
                    s.halt_c, s.wcol, s.iface_en, 1'b0, s.irq_en};
                OFS_STATUS: next_s.prdata = {24'h00_0000, s.status[7:3], 1'b0, s.prescale};
                OFS_DATA: next_s.prdata = {24'h00_0000, s.data};
                OFS_MODE: next_s.prdata = {28'h000_0000, s.wake, s.tx_mode,
                    s.addressed, s.arb_pend};
                default: next_s.pslverr = 1'b1;
            endcase
        end
        if (access && apb_req_in.pwrite) begin
            case (apb_req_in.paddr)
                OFS_OWN_ADDR: next_s.own_addr = apb_req_in.pwdata[7:0];
                OFS_CONTROL: begin
                    next_s.ack_en = apb_req_in.pwdata[CTL_ACK_EN];
                    next_s.begin_c = apb_req_in.pwdata[CTL_BEGIN];
                    next_s.halt_c = apb_req_in.pwdata[CTL_HALT];
                    next_s.iface_en = apb_req_in.pwdata[CTL_IFACE_EN];
                    next_s.irq_en = apb_req_in.pwdata[CTL_IRQ_EN];
                end
                OFS_STATUS: next_s.prescale = apb_req_in.pwdata[1:0];
                OFS_DATA: begin
                    if (s.flag) begin
                        next_s.data = apb_req_in.pwdata[7:0];
                        next_s.wcol = 1'b0;
                    end else begin
                        next_s.wcol = 1'b1;
                    end
                end
                default: next_s.pslverr = 1'b0;
            endcase
        end
        if (clear_req) begin
            // writing one clears; releases the stretched clock and wake request
            next_s.flag = 1'b0;
            next_s.stretch = 1'b0;
            next_s.wake = 1'b0;
            next_s.status = ST_NO_INFO;
        end

        // events below come after the clear so that a set always wins
        if (ev_new) begin
            case (l.ev.kind)
                EV_ADDR: begin
                    next_s.flag = 1'b1;
                    next_s.stretch = 1'b1;
                    next_s.addressed = 1'b1;
                    next_s.in_gc = l.ev.gc;
                    next_s.arb_pend = 1'b0;
                    next_s.wake = sleep_in;
                    if (l.ev.gc) begin
                        next_s.status = s.arb_pend ? ST_ARB_BCAST : ST_BCAST;
                    end else begin
                        next_s.status = s.arb_pend ? ST_ARB_OWN_W : ST_OWN_W;
                    end
                end
                EV_DATA: begin
                    next_s.flag = 1'b1;
                    next_s.stretch = 1'b1;
                    next_s.addressed = l.ev.ack;
                    // a byte seen while asleep is not kept
                    if (!sleep_in) begin
                        next_s.data = l.ev.data;
                    end
                    if (s.in_gc) begin
                        next_s.status = l.ev.ack ? ST_BC_DATA_ACK : ST_BC_DATA_NACK;
                    end else begin
                        next_s.status = l.ev.ack ? ST_DATA_ACK : ST_DATA_NACK;
                    end
                end
                default: begin
                    next_s.tx_mode = 1'b1;
                    next_s.arb_pend = 1'b0;
                end
            endcase
        end else if (stop_new) begin
            next_s.tx_mode = 1'b0;
            if (s.addressed) begin
                next_s.flag = 1'b1;
                next_s.addressed = 1'b0;
                next_s.status = ST_STOP;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s <= SYS_RST;
        end else begin
            s <= next_s;
        end
    end

    // ======================================================
    // outputs
    assign apb_rsp_out = '{prdata: s.prdata, pready: s.pready, pslverr: s.pslverr};
    assign pins_out = '{scl_drive: s.pin_low, scl_oe: s.stretch,
        sda_drive: s.pin_low, sda_oe: sda_oe};
    assign wake_req_out = s.wake;

    // ======================================================
    // checks
    AST_ADDR_FLAG: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_ADDR |=> s.flag && pins_out.scl_oe)
        else $error("address event did not raise flag and stretch");
    AST_OWN_STATUS: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_ADDR && !l.ev.gc && !s.arb_pend |=> s.status == 8'h60)
        else $error("own address status wrong");
    AST_ARB_OWN: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_ADDR && !l.ev.gc && s.arb_pend
        |=> s.status == 8'h68 && !s.arb_pend)
        else $error("lost arbitration own address status wrong");
    AST_BCAST: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_ADDR && l.ev.gc && !s.arb_pend |=> s.status == 8'h70)
        else $error("broadcast status wrong");
    AST_ARB_BCAST: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_ADDR && l.ev.gc && s.arb_pend |=> s.status == 8'h78)
        else $error("lost arbitration broadcast status wrong");
    AST_DATA_ACK: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_DATA && !s.in_gc && l.ev.ack && !sleep_in
        |=> s.status == 8'h80 && s.data == $past(l.ev.data))
        else $error("acked byte not stored or wrong status");
    AST_DATA_NACK: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_DATA && !s.in_gc && !l.ev.ack
        |=> s.status == 8'h88 && !s.addressed)
        else $error("refused byte did not leave addressed mode");
    AST_CLEAR: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        clear_req && !ev_new && !stop_new |=> !s.flag ##1 !pins_out.scl_oe)
        else $error("flag clear did not release the clock");
    AST_SLEEP_WAKE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_ADDR && sleep_in |=> wake_req_out && $stable(s.data))
        else $error("sleep match did not request wake-up");
    AST_ACK_LINE: assert property (@(posedge scl_clk_in) disable iff (s.link_clr)
        l.bit_cnt == 4'h8 && l.phase == PH_DATA |-> sda_oe == l.ack_due)
        else $error("acknowledge line does not follow decision");
    AST_NO_ACK_OFF: assert property (@(posedge scl_clk_in) disable iff (s.link_clr)
        l.bit_cnt == 4'h7 && l.phase == PH_ADDR && !l.cfg_s2[8] && start_tgl == l.start_seen
        |=> !l.ack_due)
        else $error("address acknowledged with ack_enable low");
    AST_TX_MODE: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        ev_new && l.ev.kind == EV_TX && !clear_req |=> s.tx_mode && $stable(s.flag))
        else $error("read address did not enter transmit mode");

endmodule : tws_receiver

// >>> test/tws_master_model.sv
// bus master model that drives the slave receiver's two-wire link
`timescale 1ns/1ps
module tws_master_model (
    input wire logic scl_line_in,
    input wire logic sda_line_in,
    output logic scl_out,
    output logic sda_out
);
    // ======================================================
    // bit timing, 48 ns link clock
    localparam int HALF = 24;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // sda moves mid-low only, so no false start or stop is seen
    task automatic bit_io(input logic b, output logic s);
        #(HALF / 2) sda_out = b;
        #(HALF / 2) scl_out = 1'b1;
        // waits out a stretch; only the bench timeout ends a stuck line
        wait (scl_line_in === 1'b1);
        s = sda_line_in;
        #(HALF) scl_out = 1'b0;
    endtask : bit_io
    task automatic start_cond();
        sda_out = 1'b1;
        scl_out = 1'b1;
        #(HALF) sda_out = 1'b0;
        #(HALF) scl_out = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #(HALF / 2) sda_out = 1'b0;
        #(HALF / 2) scl_out = 1'b1;
        #(HALF) sda_out = 1'b1;
        #(HALF);
    endtask : stop_cond
    // msb first, released ack slot; long low so the slave can stretch
    task automatic send(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], s);
        end
        bit_io(1'b1, ack);
        #(HALF * 21);
    endtask : send
endmodule : tws_master_model

// >>> test/two_wire_slave_receiver_test.sv
// self-checking bench of the two-wire slave receiver
`timescale 1ns/1ps
module two_wire_slave_receiver_test;
    import tws_pkg::*;
    logic clock_in = 1'b0;
    logic sys_rst_in = 1'b1;
    tws_apb_req_t req = '0;
    tws_apb_rsp_t rsp;
    tws_pins_t pins;
    logic sleep = 1'b0;
    logic arb = 1'b0;
    logic wake;
    logic scl_m;
    logic sda_m;
    logic scl_line;
    logic sda_line;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] v;
    logic e;
    logic a;
    // ======================================================
    // clock, open-drain wires, instances
    always #50 clock_in = ~clock_in;
    assign scl_line = scl_m & (pins.scl_drive | ~pins.scl_oe);
    assign sda_line = sda_m & (pins.sda_drive | ~pins.sda_oe);
    tws_receiver dut (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .apb_req_in(req),
        .apb_rsp_out(rsp),
        .scl_clk_in(scl_line),
        .sda_in(sda_line),
        .pins_out(pins),
        .sleep_in(sleep),
        .arb_lost_in(arb),
        .wake_req_out(wake)
    );
    tws_master_model m (
        .scl_line_in(scl_line),
        .sda_line_in(sda_line),
        .scl_out(scl_m),
        .sda_out(sda_m)
    );
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            summarize();
        end
    end
    // ======================================================
    // helpers
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] d);
        @(posedge clock_in);
        req <= '{paddr: ad, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
        @(posedge clock_in);
        req.penable <= 1'b1;
        @(posedge clock_in);
        // no wait count assumed; the bench timeout ends a hang
        while (rsp.pready !== 1'b1) begin
            @(posedge clock_in);
        end
        d = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask : apb
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, ad, {24'h0, d}, r);
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        apb(1'b0, ad, 32'h0, d);
    endtask : rd
    // polls the flag, then judges status with prescaler bits masked
    task automatic ev(input logic [7:0] code);
        logic [31:0] r;
        int n;
        n = 0;
        rd(OFS_CONTROL, r);
        while (r[CTL_FLAG] !== 1'b1 && n < 30) begin
            rd(OFS_CONTROL, r);
            n = n + 1;
        end
        chk("flag", 32'h1, 32'(r[CTL_FLAG]));
        rd(OFS_STATUS, r);
        chk("status", {24'h0, code}, r & 32'hF8);
        if (code != ST_STOP) chk("stretch", 32'h1, 32'(pins.scl_oe));
    endtask : ev
    task automatic clr(input logic [7:0] c);
        wr(OFS_CONTROL, c);
        repeat (2) @(posedge clock_in);
        chk("release", 32'h0, 32'(pins.scl_oe));
    endtask : clr
    task automatic end_frame(input logic a0);
        logic [31:0] r;
        m.stop_cond();
        repeat (8) @(posedge clock_in);
        if (a0) begin
            ev(ST_STOP);
            clr(8'hC4);
        end else begin
            rd(OFS_CONTROL, r);
            chk("no flag", 32'h0, 32'(r[CTL_FLAG]));
        end
    endtask : end_frame
    task automatic frame(input logic [7:0] b, input logic x);
        m.start_cond();
        m.send(b, a);
        chk("addr ack", 32'(x), 32'(a));
    endtask : frame
    task automatic byte_ev(input logic [7:0] b, input logic x, input logic [7:0] code);
        m.send(b, a);
        chk("data ack", 32'(x), 32'(a));
        ev(code);
    endtask : byte_ev
    task automatic pulse_arb();
        @(posedge clock_in);
        arb <= 1'b1;
        @(posedge clock_in);
        arb <= 1'b0;
    endtask : pulse_arb
    // ======================================================
    // scenarios
    task automatic t_regs();
        rd(OFS_STATUS, v);
        chk("status rst", 32'hF8, v);
        wr(OFS_OWN_ADDR, 8'h56);
        rd(OFS_OWN_ADDR, v);
        chk("own addr", 32'h56, v);
        wr(OFS_STATUS, 8'h03);
        rd(OFS_STATUS, v);
        chk("prescale", 32'hFB, v);
        apb(1'b0, 8'h14, 32'h0, v);
        chk("unmapped err", 32'h1, 32'(e));
        wr(OFS_CONTROL, 8'h44);
        rd(OFS_CONTROL, v);
        chk("control", 32'h44, v);
        // data write with the flag low is dropped and marks a collision
        wr(OFS_DATA, 8'h12);
        rd(OFS_CONTROL, v);
        chk("collision", 32'h4C, v);
    endtask : t_regs
    task automatic t_own();
        frame(8'h56, 1'b0);
        ev(ST_OWN_W);
        clr(8'hC4);
        byte_ev(8'hA5, 1'b0, ST_DATA_ACK);
        rd(OFS_DATA, v);
        chk("data", 32'hA5, v);
        clr(8'h84);
        byte_ev(8'h3C, 1'b1, ST_DATA_NACK);
        clr(8'hC4);
        m.send(8'h11, a);
        chk("ignored", 32'h1, 32'(a));
        end_frame(1'b0);
        frame(8'h54, 1'b1);
        end_frame(1'b0);
    endtask : t_own
    task automatic t_gc();
        frame(8'h00, 1'b1);
        end_frame(1'b0);
        wr(OFS_OWN_ADDR, 8'h57);
        frame(8'h00, 1'b0);
        ev(ST_BCAST);
        clr(8'hC4);
        byte_ev(8'h5A, 1'b0, ST_BC_DATA_ACK);
        clr(8'hC4);
        end_frame(1'b1);
    endtask : t_gc
    task automatic t_ackoff();
        wr(OFS_CONTROL, 8'h04);
        frame(8'h56, 1'b1);
        end_frame(1'b0);
        wr(OFS_CONTROL, 8'h44);
        frame(8'h56, 1'b0);
        ev(ST_OWN_W);
        clr(8'hC4);
        end_frame(1'b1);
    endtask : t_ackoff
    task automatic t_arb();
        pulse_arb();
        frame(8'h56, 1'b0);
        ev(ST_ARB_OWN_W);
        clr(8'hC4);
        byte_ev(8'h77, 1'b0, ST_DATA_ACK);
        clr(8'hC4);
        end_frame(1'b1);
        pulse_arb();
        frame(8'h00, 1'b0);
        ev(ST_ARB_BCAST);
        clr(8'hC4);
        end_frame(1'b1);
    endtask : t_arb
    task automatic t_read();
        frame(8'h57, 1'b0);
        rd(OFS_MODE, v);
        chk("transmit mode", 32'h1, 32'(v[2]));
        rd(OFS_CONTROL, v);
        chk("no flag on read", 32'h0, 32'(v[CTL_FLAG]));
        end_frame(1'b0);
    endtask : t_read
    task automatic t_sleep();
        @(posedge clock_in);
        sleep <= 1'b1;
        frame(8'h56, 1'b0);
        repeat (10) @(posedge clock_in);
        chk("wake", 32'h1, 32'(wake));
        chk("sleep stretch", 32'h1, 32'(pins.scl_oe));
        sleep <= 1'b0;
        ev(ST_OWN_W);
        clr(8'hC4);
        chk("wake off", 32'h0, 32'(wake));
        byte_ev(8'h42, 1'b0, ST_DATA_ACK);
        clr(8'hC4);
        end_frame(1'b1);
    endtask : t_sleep
    // ======================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        t_regs();
        t_own();
        t_gc();
        t_ackoff();
        t_arb();
        t_read();
        t_sleep();
        summarize();
    end
endmodule : two_wire_slave_receiver_test
